// *** shared/tdoc_regs.vh ***
// Purpose: register offsets, reset values and field positions of the touch decision block
// Assumes: 8-bit registers at byte offsets, 100 MHz mclk_i
// Notes:   definitions only
`ifndef TDOC_REGS_VH
`define TDOC_REGS_VH

// button parameter offsets
`define TD_ADDR_BTN_AVG      8'h22
`define TD_ADDR_BTN_NEG      8'h23
`define TD_ADDR_BTN_NCNT     8'h24
`define TD_ADDR_BTN_HYST     8'h25
`define TD_ADDR_BTN_STUCK    8'h26
// slider parameter offsets
`define TD_ADDR_SLD_CFG      8'h27
`define TD_ADDR_SLD_STUCK    8'h28
`define TD_ADDR_SLD_HYST     8'h29
`define TD_ADDR_SLD_NORM_HI  8'h2b
`define TD_ADDR_SLD_NORM_LO  8'h2c
`define TD_ADDR_SLD_AVG      8'h2d
`define TD_ADDR_SLD_NEG      8'h2e
`define TD_ADDR_SLD_NCNT     8'h2f
`define TD_ADDR_SLD_MOVE     8'h30

// reset values
`define TD_RST_BTN_AVG       8'h50
`define TD_RST_BTN_NEG       8'h50
`define TD_RST_BTN_NCNT      8'h01
`define TD_RST_BTN_HYST      8'h0a
`define TD_RST_BTN_STUCK     8'h00
`define TD_RST_SLD_CFG       8'h00
`define TD_RST_SLD_STUCK     8'h00
`define TD_RST_SLD_HYST      8'h03
`define TD_RST_SLD_NORM_HI   8'h01
`define TD_RST_SLD_NORM_LO   8'h80
`define TD_RST_SLD_AVG       8'h50
`define TD_RST_SLD_NEG       8'h50
`define TD_RST_SLD_NCNT      8'h01
`define TD_RST_SLD_MOVE      8'h02

// slider debounce field layout, upper nibble reserved
`define TD_CFG_REL_HI        3
`define TD_CFG_REL_LO        2
`define TD_CFG_TCH_HI        1
`define TD_CFG_TCH_LO        0
`define TD_CFG_MASK          8'h0f

// geometry and scaling
`define TD_NBTN              6
`define TD_TICK_W            16
`define TD_THR_W             12
`define TD_PCT_FULL          20'h00064
`define TD_AVG_TRIG_MIN      3'h3
`define TD_DEB_OFF           2'h0
`define TD_NCNT_RESERVED     8'h00

// timing: one stuck-at step
`define TD_SEC_MS            1000
`define TD_CLK_MHZ           100
`endif

// *** logic/tdoc_chan.v ***
// Purpose: one sensing channel: debounced touch/release, stuck-at, averaging hold, negative count
// Assumes: sample_i pulses once per scan period, sec_tick_i once per second
// Notes:   touch and release conditions are formed by the caller
`include "tdoc_regs.vh"
module tdoc_chan (
    input  wire                    mclk_i,
    input  wire                    rst_n_i,
    input  wire                    sample_i,
    input  wire signed [15:0]      ticks_i,
    input  wire                    touch_cond_i,
    input  wire                    release_cond_i,
    input  wire        [15:0]      avg_level_i,
    input  wire        [15:0]      neg_level_i,
    input  wire        [7:0]       neg_limit_i,
    input  wire        [1:0]       deb_touch_i,
    input  wire        [1:0]       deb_rel_i,
    input  wire        [7:0]       stuck_code_i,
    input  wire                    sec_tick_i,
    input  wire                    comp_done_i,
    output reg                     touched_o,
    output reg                     avg_hold_o,
    output reg                     neg_trig_o,
    output reg                     lock_o
);
    reg        [2:0]   deb_cnt;
    reg        [7:0]   neg_cnt;
    reg        [7:0]   sec_cnt;
    wire       [7:0]   limit_eff;
    wire       [7:0]   neg_inc;
    wire       [2:0]   deb_inc;
    wire               below_neg;
    wire               stuck_fire;

    // reserved limit code behaves as one sample
    assign limit_eff  = (neg_limit_i == `TD_NCNT_RESERVED) ? 8'h01 : neg_limit_i;
    assign neg_inc    = (neg_cnt == 8'hff) ? neg_cnt : neg_cnt + 8'h01;
    assign deb_inc    = deb_cnt + 3'h1;
    assign below_neg  = ticks_i < -$signed(neg_level_i);
    // timer expires on the second that reaches the code, zero never fires
    assign stuck_fire = touched_o && sec_tick_i && (stuck_code_i != 8'h00)
                        && ({1'b0, sec_cnt} + 9'h001 >= {1'b0, stuck_code_i});

    // averaging hold and negative counter, sampled per scan
    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            avg_hold_o <= 1'b0;
            neg_trig_o <= 1'b0;
            neg_cnt    <= 8'h00;
        end
        else
        begin
            neg_trig_o <= 1'b0;
            if (sample_i)
            begin
                avg_hold_o <= ticks_i >= $signed(avg_level_i);
                if (below_neg)
                begin
                    neg_cnt <= neg_inc;
                    if (neg_inc >= limit_eff)
                        neg_trig_o <= 1'b1;
                end
                else
                    neg_cnt <= 8'h00;
            end
            if (comp_done_i)
                neg_cnt <= 8'h00;
        end
    end

    // touch state with debounce and stuck-at lockout
    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            touched_o <= 1'b0;
            lock_o    <= 1'b0;
            deb_cnt   <= 3'h0;
            sec_cnt   <= 8'h00;
        end
        else if (stuck_fire)
        begin
            touched_o <= 1'b0;
            lock_o    <= 1'b1;
            deb_cnt   <= 3'h0;
            sec_cnt   <= 8'h00;
        end
        else
        begin
            if (touched_o && sec_tick_i && (stuck_code_i != 8'h00))
                sec_cnt <= sec_cnt + 8'h01;
            if (sample_i)
            begin
                if (!touched_o)
                begin
                    if (release_cond_i)
                        lock_o <= 1'b0;
                    if (touch_cond_i && !lock_o)
                    begin
                        // code 00..11 needs 1..4 samples
                        if (deb_inc >= {1'b0, deb_touch_i} + 3'h1)
                        begin
                            touched_o <= 1'b1;
                            deb_cnt   <= 3'h0;
                            sec_cnt   <= 8'h00;
                        end
                        else
                            deb_cnt <= deb_inc;
                    end
                    else
                        deb_cnt <= 3'h0;
                end
                else if (release_cond_i)
                begin
                    if (deb_inc >= {1'b0, deb_rel_i} + 3'h1)
                    begin
                        touched_o <= 1'b0;
                        deb_cnt   <= 3'h0;
                    end
                    else
                        deb_cnt <= deb_inc;
                end
                else
                    deb_cnt <= 3'h0;
            end
        end
    end
endmodule // tdoc_chan

// *** logic/tdoc_top.v ***
// Purpose: touch/release decision and offset compensation trigger for buttons and slider
// Assumes: tick inputs and scan strobe come from front-end logic on mclk_i
// Notes:   registers sit at their documented offsets behind the register port
`include "tdoc_regs.vh"
module tdoc_top #(
    parameter SEC_CYCLES = `TD_SEC_MS * 1000 * `TD_CLK_MHZ
) (
    input  wire                    mclk_i,
    input  wire                    rst_n_i,
    input  wire                    scan_strobe_i,
    input  wire [95:0]             btn_ticks_i,
    input  wire [71:0]             btn_thresh_i,
    input  wire [15:0]             sld_ticks_i,
    input  wire [15:0]             sld_pressure_i,
    input  wire                    comp_done_i,
    input  wire [7:0]              reg_addr_i,
    input  wire [7:0]              reg_wdata_i,
    input  wire                    reg_wr_i,
    input  wire                    reg_rd_i,
    output reg  [7:0]              reg_rdata_o,
    output wire [5:0]              btn_touched_o,
    output wire [5:0]              btn_avg_hold_o,
    output wire                    sld_touched_o,
    output wire                    sld_avg_hold_o,
    output reg                     comp_req_o,
    output wire [15:0]             sld_norm_o,
    output wire [7:0]              sld_move_thresh_o
);
    localparam CS_IDLE = 1'b0;
    localparam CS_BUSY = 1'b1;

    // configuration registers
    reg        [7:0]   btn_average_threshold;
    reg        [7:0]   button_negative_comp_threshold;
    reg        [7:0]   button_negative_count_limit;
    reg        [7:0]   button_hysteresis;
    reg        [7:0]   button_stuck_timeout;
    reg        [7:0]   slider_debounce_cfg;
    reg        [7:0]   slider_stuck_timeout;
    reg        [7:0]   slider_hysteresis;
    reg        [7:0]   slider_norm_high;
    reg        [7:0]   slider_norm_low;
    reg        [7:0]   slider_average_threshold;
    reg        [7:0]   slider_negative_comp_threshold;
    reg        [7:0]   slider_negative_count_limit;
    reg        [7:0]   slider_move_threshold;

    reg        [26:0]  sec_cnt;
    reg                sec_tick;
    reg                sample_d;
    reg                comp_state;
    reg                next_comp_state;
    reg        [7:0]   next_rdata;

    wire       [5:0]   btn_touch_cond;
    wire       [5:0]   btn_rel_cond;
    wire       [5:0]   btn_neg_trig;
    wire               sld_neg_trig;
    wire               sld_touch_cond;
    wire               sld_rel_cond;
    wire               many_high;
    wire               comp_trig;
    wire       [15:0]  sld_avg_level;

    // code of four ticks per step
    function [15:0] code_ticks;
        input [7:0] code;
        begin
            code_ticks = {6'h00, code, 2'b00};
        end
    endfunction

    // threshold times hysteresis percent
    function [15:0] hyst_ticks;
        input [11:0] thr;
        input [7:0]  pct;
        reg   [19:0] prod;
        reg   [19:0] quot;
        begin
            prod       = {8'h00, thr} * {12'h000, pct};
            quot       = prod / `TD_PCT_FULL;
            hyst_ticks = quot[15:0];
        end
    endfunction

    // number of set bits of a six-bit vector
    function [2:0] pop6;
        input [5:0] v;
        integer     k;
        begin
            pop6 = 3'h0;
            for (k = 0; k < `TD_NBTN; k = k + 1)
                pop6 = pop6 + {2'b00, v[k]};
        end
    endfunction

    // one pulse per second for the stuck-at timers
    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            sec_cnt  <= 27'h0000000;
            sec_tick <= 1'b0;
        end
        else if (sec_cnt == SEC_CYCLES[26:0] - 27'h0000001)
        begin
            sec_cnt  <= 27'h0000000;
            sec_tick <= 1'b1;
        end
        else
        begin
            sec_cnt  <= sec_cnt + 27'h0000001;
            sec_tick <= 1'b0;
        end
    end

    // register writes
    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            btn_average_threshold          <= `TD_RST_BTN_AVG;
            button_negative_comp_threshold <= `TD_RST_BTN_NEG;
            button_negative_count_limit    <= `TD_RST_BTN_NCNT;
            button_hysteresis              <= `TD_RST_BTN_HYST;
            button_stuck_timeout           <= `TD_RST_BTN_STUCK;
            slider_debounce_cfg            <= `TD_RST_SLD_CFG;
            slider_stuck_timeout           <= `TD_RST_SLD_STUCK;
            slider_hysteresis              <= `TD_RST_SLD_HYST;
            slider_norm_high               <= `TD_RST_SLD_NORM_HI;
            slider_norm_low                <= `TD_RST_SLD_NORM_LO;
            slider_average_threshold       <= `TD_RST_SLD_AVG;
            slider_negative_comp_threshold <= `TD_RST_SLD_NEG;
            slider_negative_count_limit    <= `TD_RST_SLD_NCNT;
            slider_move_threshold          <= `TD_RST_SLD_MOVE;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                `TD_ADDR_BTN_AVG:     btn_average_threshold          <= reg_wdata_i;
                `TD_ADDR_BTN_NEG:     button_negative_comp_threshold <= reg_wdata_i;
                `TD_ADDR_BTN_NCNT:    button_negative_count_limit    <= reg_wdata_i;
                `TD_ADDR_BTN_HYST:    button_hysteresis              <= reg_wdata_i;
                `TD_ADDR_BTN_STUCK:   button_stuck_timeout           <= reg_wdata_i;
                `TD_ADDR_SLD_CFG:     slider_debounce_cfg   <= reg_wdata_i & `TD_CFG_MASK;
                `TD_ADDR_SLD_STUCK:   slider_stuck_timeout           <= reg_wdata_i;
                `TD_ADDR_SLD_HYST:    slider_hysteresis              <= reg_wdata_i;
                `TD_ADDR_SLD_NORM_HI: slider_norm_high               <= reg_wdata_i;
                `TD_ADDR_SLD_NORM_LO: slider_norm_low                <= reg_wdata_i;
                `TD_ADDR_SLD_AVG:     slider_average_threshold       <= reg_wdata_i;
                `TD_ADDR_SLD_NEG:     slider_negative_comp_threshold <= reg_wdata_i;
                `TD_ADDR_SLD_NCNT:    slider_negative_count_limit    <= reg_wdata_i;
                `TD_ADDR_SLD_MOVE:    slider_move_threshold          <= reg_wdata_i;
                default:              ;
            endcase
        end
    end

    // read data select, unmapped offsets read zero
    always @*
    begin
        case (reg_addr_i)
            `TD_ADDR_BTN_AVG:     next_rdata = btn_average_threshold;
            `TD_ADDR_BTN_NEG:     next_rdata = button_negative_comp_threshold;
            `TD_ADDR_BTN_NCNT:    next_rdata = button_negative_count_limit;
            `TD_ADDR_BTN_HYST:    next_rdata = button_hysteresis;
            `TD_ADDR_BTN_STUCK:   next_rdata = button_stuck_timeout;
            `TD_ADDR_SLD_CFG:     next_rdata = slider_debounce_cfg;
            `TD_ADDR_SLD_STUCK:   next_rdata = slider_stuck_timeout;
            `TD_ADDR_SLD_HYST:    next_rdata = slider_hysteresis;
            `TD_ADDR_SLD_NORM_HI: next_rdata = slider_norm_high;
            `TD_ADDR_SLD_NORM_LO: next_rdata = slider_norm_low;
            `TD_ADDR_SLD_AVG:     next_rdata = slider_average_threshold;
            `TD_ADDR_SLD_NEG:     next_rdata = slider_negative_comp_threshold;
            `TD_ADDR_SLD_NCNT:    next_rdata = slider_negative_count_limit;
            `TD_ADDR_SLD_MOVE:    next_rdata = slider_move_threshold;
            default:              next_rdata = 8'h00;
        endcase
    end

    // read data register, held between reads
    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i)
            reg_rdata_o <= next_rdata;
    end

    // button channels with shared hysteresis percent
    genvar g;
    generate
        for (g = 0; g < `TD_NBTN; g = g + 1)
        begin : g_btn
            wire signed [17:0] tk;
            wire signed [17:0] thr;
            wire signed [17:0] hy;
            assign tk  = {{2{btn_ticks_i[16*g+15]}}, btn_ticks_i[16*g +: 16]};
            assign thr = {6'h00, btn_thresh_i[12*g +: 12]};
            assign hy  = {2'b00, hyst_ticks(btn_thresh_i[12*g +: 12], button_hysteresis)};
            assign btn_touch_cond[g] = tk > thr + hy;
            assign btn_rel_cond[g]   = tk < thr - hy;

            tdoc_chan u_chan (
                .mclk_i         (mclk_i),
                .rst_n_i        (rst_n_i),
                .sample_i       (scan_strobe_i),
                .ticks_i        (btn_ticks_i[16*g +: 16]),
                .touch_cond_i   (btn_touch_cond[g]),
                .release_cond_i (btn_rel_cond[g]),
                .avg_level_i    (code_ticks(btn_average_threshold)),
                .neg_level_i    (code_ticks(button_negative_comp_threshold)),
                .neg_limit_i    (button_negative_count_limit),
                .deb_touch_i    (`TD_DEB_OFF),
                .deb_rel_i      (`TD_DEB_OFF),
                .stuck_code_i   (button_stuck_timeout),
                .sec_tick_i     (sec_tick),
                .comp_done_i    (comp_done_i),
                .touched_o      (btn_touched_o[g]),
                .avg_hold_o     (btn_avg_hold_o[g]),
                .neg_trig_o     (btn_neg_trig[g]),
                .lock_o         ()
            );
        end
    endgenerate

    // slider: touched above hysteresis, released at zero pressure
    assign sld_touch_cond = sld_pressure_i > code_ticks(slider_hysteresis);
    assign sld_rel_cond   = sld_pressure_i == 16'h0000;
    // strictly above the averaging level suspends slider averaging
    assign sld_avg_level  = code_ticks(slider_average_threshold) + 16'h0001;

    tdoc_chan u_sld (
        .mclk_i         (mclk_i),
        .rst_n_i        (rst_n_i),
        .sample_i       (scan_strobe_i),
        .ticks_i        (sld_ticks_i),
        .touch_cond_i   (sld_touch_cond),
        .release_cond_i (sld_rel_cond),
        .avg_level_i    (sld_avg_level),
        .neg_level_i    (code_ticks(slider_negative_comp_threshold)),
        .neg_limit_i    (slider_negative_count_limit),
        .deb_touch_i    (slider_debounce_cfg[`TD_CFG_TCH_HI:`TD_CFG_TCH_LO]),
        .deb_rel_i      (slider_debounce_cfg[`TD_CFG_REL_HI:`TD_CFG_REL_LO]),
        .stuck_code_i   (slider_stuck_timeout),
        .sec_tick_i     (sec_tick),
        .comp_done_i    (comp_done_i),
        .touched_o      (sld_touched_o),
        .avg_hold_o     (sld_avg_hold_o),
        .neg_trig_o     (sld_neg_trig),
        .lock_o         ()
    );

    // settings handed to slider position and movement logic
    assign sld_norm_o        = {slider_norm_high, slider_norm_low};
    assign sld_move_thresh_o = slider_move_threshold;

    // averaging flags are valid the cycle after the scan strobe
    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
            sample_d <= 1'b0;
        else
            sample_d <= scan_strobe_i;
    end

    assign many_high = sample_d && (pop6(btn_avg_hold_o) >= `TD_AVG_TRIG_MIN);
    assign comp_trig = many_high || (|btn_neg_trig) || sld_neg_trig;

    // compensation request until the front end reports new baselines
    always @*
    begin
        case (comp_state)
            CS_IDLE: next_comp_state = comp_trig ? CS_BUSY : CS_IDLE;
            CS_BUSY: next_comp_state = (comp_done_i && !comp_trig) ? CS_IDLE : CS_BUSY;
            default: next_comp_state = CS_IDLE;
        endcase
    end

    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            comp_state <= CS_IDLE;
            comp_req_o <= 1'b0;
        end
        else
        begin
            comp_state <= next_comp_state;
            comp_req_o <= next_comp_state == CS_BUSY;
        end
    end
endmodule // tdoc_top

// *** bench/tdoc_top_monitor.sv ***
// Purpose: port checks of the touch decision block
// Assumes: one clock, synchronous active-low reset
// Notes:   tick limits lie beyond any register code
module tdoc_top_monitor (
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    input wire logic        scan_strobe_i,
    input wire logic [95:0] btn_ticks_i,
    input wire logic [15:0] sld_ticks_i,
    input wire logic        comp_done_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic [5:0]  btn_touched_o,
    input wire logic [5:0]  btn_avg_hold_o,
    input wire logic        sld_touched_o,
    input wire logic        sld_avg_hold_o,
    input wire logic        comp_req_o,
    input wire logic [15:0] sld_norm_o,
    input wire logic [7:0]  sld_move_thresh_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // button 0 and slider ticks as signed values
    wire signed [15:0] t0 = btn_ticks_i[15:0];
    wire signed [15:0] ts = sld_ticks_i;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    a_reset_regs: assert property ($rose(rst_n_i) |-> sld_norm_o == 16'h0180
        && sld_move_thresh_o == 8'h02) else $error("bad norm or move after reset");
    a_reset_state: assert property ($rose(rst_n_i) |-> !comp_req_o
        && reg_rdata_o == 8'h00 && btn_touched_o == 6'h00) else $error("state not cleared");
    a_hold_full: assert property (scan_strobe_i && t0 >= 16'sd1020
        |=> btn_avg_hold_o[0]) else $error("button hold missing");
    a_hold_neg: assert property (scan_strobe_i && t0 < 16'sd0
        |=> !btn_avg_hold_o[0]) else $error("button hold on negative ticks");
    a_sld_hold: assert property (scan_strobe_i && ts > 16'sd1020
        |=> sld_avg_hold_o) else $error("slider hold missing");
    a_btn_release: assert property (scan_strobe_i && t0 < -16'sd8000
        |=> !btn_touched_o[0]) else $error("button kept touched");
    a_touch_on_scan: assert property ((btn_touched_o & ~$past(btn_touched_o)) != 6'h00
        |-> $past(scan_strobe_i)) else $error("touch without scan");
    a_comp_rise: assert property ($rose(comp_req_o) |-> $past(scan_strobe_i)
        || $past(scan_strobe_i, 2)) else $error("request without scan");
    a_comp_done: assert property (comp_done_i && !scan_strobe_i && !$past(scan_strobe_i)
        && !$past(scan_strobe_i, 2) |=> !comp_req_o) else $error("request held after done");
    c_comp: cover property ($rose(comp_req_o));
    c_stuck: cover property ($fell(btn_touched_o[0]) && !$past(scan_strobe_i));
    c_slider: cover property ($rose(sld_touched_o));
endmodule // tdoc_top_monitor

// *** bench/tdoc_front_model.sv ***
// Purpose: front end answering compensation requests
// Assumes: request level stays up until done is seen
// Notes:   answer delay chosen per bench phase through dly_i
module tdoc_front_model (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       req_i,
    input  wire logic [2:0] dly_i,
    output logic            done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt;
    initial done_o = 1'b0;
    // measure for dly_i cycles, store baselines, one-cycle done
    always @(posedge mclk_i)
    begin
        done_o <= 1'b0;
        if (!rst_n_i || !req_i || done_o)
            cnt <= 3'h0;
        else if (cnt + 3'h1 == dly_i)
            done_o <= 1'b1;
        else
            cnt <= cnt + 3'h1;
    end
endmodule // tdoc_front_model

// *** bench/tb.sv ***
// Purpose: self-checking bench of the touch decision block
// Assumes: 100 MHz clock, 20-cycle stuck-at second
// Notes:   results noted in queues, checked by the bench's compare block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [143:0] RT = 144'h0000_5050_010a_0000_0003_0001_8050_5001_0200;
    logic        mclk_i = 0, rst_n_i = 0, scan_strobe_i = 0, reg_wr_i = 0, reg_rd_i = 0;
    logic [95:0] btn_ticks_i = '0;
    logic [71:0] btn_thresh_i = '0;
    logic [15:0] sld_ticks_i = '0, sld_pressure_i = '0, sld_norm_o, rq[$], sq[$], cq[$];
    logic [7:0]  reg_addr_i = '0, reg_wdata_i = '0, rv[0:255], reg_rdata_o, sld_move_thresh_o;
    logic [5:0]  btn_touched_o, btn_avg_hold_o, bt, lk;
    logic [2:0]  dly = 3'h2;
    logic        sld_touched_o, sld_avg_hold_o, comp_req_o, comp_done_i, st;
    logic        rd_d = 0, s1 = 0, s2 = 0, s3 = 0;
    int          miscompares = 0, comparisons = 0, tk[0:6], thr[0:5], nc[0:6], p, ct, cr;
    always #5 mclk_i = ~mclk_i;
    tdoc_top #(.SEC_CYCLES(20)) u_tdoc_top (.mclk_i, .rst_n_i, .scan_strobe_i, .btn_ticks_i,
        .btn_thresh_i, .sld_ticks_i, .sld_pressure_i, .comp_done_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .btn_touched_o, .btn_avg_hold_o, .sld_touched_o,
        .sld_avg_hold_o, .comp_req_o, .sld_norm_o, .sld_move_thresh_o);
    tdoc_front_model u_tdoc_front_model (.mclk_i, .rst_n_i, .req_i(comp_req_o), .dly_i(dly),
        .done_o(comp_done_i));
    function automatic int r(input logic [7:0] a);
        return int'(rv[a]);
    endfunction
    // ticks idle, negative, near threshold or full touch
    function automatic int rt(input int th);
        case ($urandom % 4)
            0: return -int'($urandom % 700);
            1: return th - th / 5 + int'($urandom % (th * 2 / 5 + 1));
            2: return 1100 + int'($urandom % 400);
            default: return int'($urandom % 200);
        endcase
    endfunction
    task chk(input logic [15:0] s, e);
        comparisons++;
        if (s !== e)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task conclude;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task reset;
        rst_n_i = 1'b0;
        repeat (8) @(posedge mclk_i);
        #1 rst_n_i = 1'b1;
        for (int i = 0; i < 18; i++) rv[8'h20 + i] = RT[143 - 8 * i -: 8];
        {bt, lk, st, ct, cr} = '0;
        nc = '{default: 0};
    endtask
    task wr(input logic [7:0] a, d);
        @(posedge mclk_i) #1 {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
        rv[a] = (a > 8'h21 && a < 8'h31 && a != 8'h2a) ? d & (a == 8'h27 ? 8'h0f : 8'hff) : 8'h00;
        @(posedge mclk_i) #1 reg_wr_i = 1'b0;
    endtask
    task rd(input logic [7:0] a);
        rq.push_back({8'h00, rv[a]});
        @(posedge mclk_i) #1 {reg_addr_i, reg_rd_i} = {a, 1'b1};
        @(posedge mclk_i) #1 reg_rd_i = 1'b0;
    endtask
    // one scan: drive ticks, note the expected decisions
    task sense;
        int hy, ta, tr, nh;
        logic [5:0] hv;
        @(posedge mclk_i) #1;
        for (int g = 0; g < 6; g++)
            {btn_ticks_i[16*g+:16], btn_thresh_i[12*g+:12]} = {tk[g][15:0], thr[g][11:0]};
        {sld_ticks_i, sld_pressure_i, scan_strobe_i, tr, nh} = {tk[6][15:0], p[15:0], 1'b1, 64'h0};
        for (int g = 0; g < 7; g++)
        begin
            ta = g < 6 ? 0 : 11;
            nc[g] = tk[g] < -4 * r(8'h23 + ta) ? nc[g] + 1 : 0;
            if (nc[g] >= (r(8'h24 + ta) > 0 ? r(8'h24 + ta) : 1)) tr = 1;
        end
        for (int g = 0; g < 6; g++)
        begin
            hy = thr[g] * r(8'h25) / 100;
            if (tk[g] > thr[g] + hy && !lk[g]) bt[g] = 1'b1;
            else if (tk[g] < thr[g] - hy) {bt[g], lk[g]} = 2'b00;
            hv[g] = tk[g] >= 4 * r(8'h22);
            nh += hv[g];
        end
        if (!st) ct = p > 4 * r(8'h29) ? ct + 1 : 0;
        else cr = p == 0 ? cr + 1 : 0;
        if (ct > r(8'h27) % 4) {st, ct} = {1'b1, 32'h0};
        if (cr > r(8'h27) / 4) {st, cr} = {1'b0, 32'h0};
        if (tr || nh >= 3) nc = '{default: 0};
        sq.push_back({2'b00, bt, hv, st, tk[6] > 4 * r(8'h2d)});
        cq.push_back({15'h0, tr || nh >= 3});
        @(posedge mclk_i) #1 scan_strobe_i = 1'b0;
        repeat (10) @(posedge mclk_i);
    endtask
    // compare read data, scan decisions and request against the notes
    always @(posedge mclk_i)
    begin
        if (rd_d) chk({8'h00, reg_rdata_o}, rq.pop_front());
        if (s1) chk({2'b00, btn_touched_o, btn_avg_hold_o, sld_touched_o, sld_avg_hold_o},
            sq.pop_front());
        if (s3) chk({15'h0, comp_req_o}, cq.pop_front());
        {rd_d, s1, s2, s3} <= {reg_rd_i, scan_strobe_i, s1, s2};
    end
    initial
    begin
        #200us miscompares++;
        conclude;
    end
    // registers, random scans with both limits, then stuck-at release
    initial
    begin
        void'($urandom(32'h8a18d531));
        reset;
        for (int a = 8'h20; a < 8'h32; a++) rd(a);
        for (int a = 8'h20; a < 8'h32; a++) wr(a, $urandom);
        for (int a = 8'h20; a < 8'h32; a++) rd(a);
        chk(sld_norm_o, {rv[8'h2b], rv[8'h2c]});
        chk({8'h00, sld_move_thresh_o}, {8'h00, rv[8'h30]});
        reset;
        for (int ph = 0; ph < 2; ph++)
        begin
            wr(8'h24, ph ? 2 + $urandom % 2 : 1);
            wr(8'h2f, 1 + $urandom % 3);
            wr(8'h25, $urandom % 101);
            wr(8'h29, $urandom % 8);
            wr(8'h27, $urandom % 16);
            wr(8'h2d, $urandom % 256);
            dly = 2 + $urandom % 5;
            for (int g = 0; g < 6; g++) thr[g] = 100 + $urandom % 901;
            repeat (30)
            begin
                for (int g = 0; g < 7; g++) tk[g] = rt(g < 6 ? thr[g] : 300);
                p = $urandom % 2 ? 0 : $urandom % 40;
                sense;
            end
        end
        wr(8'h26, 8'h01);
        wr(8'h27, 8'h00);
        wr(8'h28, 8'h01);
        tk = '{default: -1};
        p = 0;
        sense;
        tk[0] = 3000;
        p = 40;
        sense;
        repeat (60) @(posedge mclk_i);
        {bt[0], lk[0]} = 2'b01;
        {st, p} = '0;
        sense;
        tk[0] = -9000;
        sense;
        tk[0] = 3000;
        sense;
        conclude;
    end
endmodule // tb
bind tdoc_top tdoc_top_monitor u_tdoc_top_monitor (.mclk_i, .rst_n_i, .scan_strobe_i,
    .btn_ticks_i, .sld_ticks_i, .comp_done_i, .reg_rdata_o, .btn_touched_o, .btn_avg_hold_o,
    .sld_touched_o, .sld_avg_hold_o, .comp_req_o, .sld_norm_o, .sld_move_thresh_o);
